// >>> hw/pusc_regs.svh
// power-up strap capture: field positions, codes and reset values
`ifndef PUSC_REGS_SVH
`define PUSC_REGS_SVH

`define PUSC_IMAGE_RESET        32'h0000_0000
`define PUSC_BUS_HI             31
`define PUSC_BUS_LO             30
`define PUSC_BASE_HI            29
`define PUSC_BASE_LO            27
`define PUSC_MODE_BIT           26
`define PUSC_LEGACY_BIT         25
`define PUSC_RSV24_BIT          24
`define PUSC_RSV_HI             23
`define PUSC_RSV_LO             16
`define PUSC_DAC_HI             15
`define PUSC_DAC_LO             12
`define PUSC_RSV11_HI           11
`define PUSC_RSV11_LO           9
`define PUSC_EXTREG_BIT         8
`define PUSC_CLK_HI             7
`define PUSC_CLK_LO             5
`define PUSC_DEPTH_BIT          4
`define PUSC_SAM_BIT            3
`define PUSC_PROM_HI            2
`define PUSC_PROM_LO            1
`define PUSC_BOARD_BIT          0
`define PUSC_BASE_0             16'h9100
`define PUSC_BASE_1             16'h9110
`define PUSC_BASE_2             16'h9120
`define PUSC_BASE_3             16'h9130
`define PUSC_CLOCK_SELECT_OUT_EXTREG_BIT   2
// edges in capture state before the synchroniser holds only post-release samples
`define PUSC_SYNC_FILL          2'h2

`endif

// >>> hw/pusc_pkg.sv
// power-up strap capture: shared types
package pusc_pkg;
    typedef enum logic [1:0] {
        PUSC_BUS_TEST = 2'h0,
        PUSC_BUS_PCI  = 2'h1,
        PUSC_BUS_VLB  = 2'h2,
        PUSC_BUS_RSV  = 2'h3
    } pusc_bus_type;

    typedef enum logic [3:0] {
        PUSC_DAC_STD  = 4'h0,
        PUSC_DAC_WIDE = 4'h8
    } pusc_dac_type;

    typedef enum logic [2:0] {
        PUSC_CLK_CLOCK_GENERATOR_KIND = 3'h0,
        PUSC_CLK_FIXED = 3'h1
    } pusc_clk_type;

    typedef enum logic [1:0] {
        PUSC_ST_RESET   = 2'h0,
        PUSC_ST_CAPTURE = 2'h1,
        PUSC_ST_HOLD    = 2'h2
    } pusc_state_type;
endpackage : pusc_pkg

// >>> hw/pusc_sync.sv
// power-up strap capture: three-stage pin synchroniser with agreement detect
`timescale 1ns/10ps
`include "pusc_regs.svh"
module pusc_sync #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    // pins and synchronised result
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out,
    output logic                  stable_out
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    // first stage feeds only the second
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    assign level_out  = s3_q;
    assign stable_out = (s2_q == s3_q);
endmodule : pusc_sync

// >>> hw/pusc_core.sv
// power-up strap capture: samples the data bus after reset and holds the image
//
// How it works
// - on reset release, sample the data bus once as power-up configuration
// - weak internal pull-down on every data bit; unstrapped bits read zero
// - captured levels held in a 32-bit read-only image register
// - bit 26 gives initial operating mode: 0 native, 1 emulation
// - bit 25 gives initial legacy display presence; 1 means absent
// - bits 15:12 give palette dac type: 0000 family, 1000 wide dac
// - bit 8 flags external board registers, reached when clock select bit 2 set
// - bits 7:5 clock arrangement: 000 synthesizer, 001 fixed memory clock
// - bit 4 memory chip depth: 0 deep 256k, 1 deep 128k
// - bit 3 serial buffer size: 0 full, 1 half shift registers
// - bits 2:1 identify serial prom; 00 is 128x8 two-wire or none
// - bit 0 board location: 0 motherboard, 1 add-in board
`timescale 1ns/10ps
`include "pusc_regs.svh"
module pusc_core #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input  wire logic             clock_in,
    input  wire logic             reset_n_in,
    // frame buffer data bus pins
    input  wire logic [WIDTH-1:0] data_bus_in,
    output logic      [WIDTH-1:0] data_pull_oe_out,
    output logic      [WIDTH-1:0] data_pull_level_out,
    // software read port
    input  wire logic             image_read_in,
    output logic      [WIDTH-1:0] power_up_strap_image_out,
    output logic                  image_valid_out,
    // decoded straps
    output pusc_pkg::pusc_bus_type host_bus_out,
    output logic                  host_bus_reserved_out,
    output logic      [15:0]      config_port_base_select_out,
    output logic                  config_port_base_valid_out,
    output logic                  initial_operating_mode_out,
    output logic                  initial_legacy_absent_out,
    output logic      [7:0]       pci_sub_class_out,
    output pusc_pkg::pusc_dac_type palette_dac_type_out,
    output logic                  palette_dac_known_out,
    output logic                  ext_regs_present_out,
    input  wire logic [2:0]       clock_select_out_in,
    output logic                  ext_regs_select_out,
    output pusc_pkg::pusc_clk_type clock_generator_kind_out,
    output logic                  fixed_memory_clock_out,
    output logic                  memory_depth_128k_out,
    output logic                  serial_buffer_size_half_out,
    output logic      [1:0]       serial_prom_type_out,
    output logic                  add_in_board_out,
    output logic                  strap_fault_out
);
    // ------------------------------------------------------------
    // synchronised pins
    // ------------------------------------------------------------
    logic [WIDTH-1:0] bus_level;
    logic             bus_stable;

    pusc_sync #(
        .WIDTH (WIDTH)
    ) u_sync (
        .clock_in   (clock_in),
        .reset_n_in (reset_n_in),
        .pin_in     (data_bus_in),
        .level_out  (bus_level),
        .stable_out (bus_stable)
    );

    // weak pull-down: enable stays high, level is low, so a bare pin reads zero
    assign data_pull_oe_out    = {WIDTH{1'b1}};
    assign data_pull_level_out = '0;

    // ------------------------------------------------------------
    // capture sequencer
    // ------------------------------------------------------------
    pusc_pkg::pusc_state_type state_q;
    pusc_pkg::pusc_state_type state_d;
    logic [WIDTH-1:0]         image_q;
    logic                     take;
    logic [1:0]               fill_q;
    logic [1:0]               fill_d;
    wire                      in_capture = (state_q == pusc_pkg::PUSC_ST_CAPTURE);
    wire                      filled     = (fill_q == `PUSC_SYNC_FILL);

    // reset zeros agree too, so agreement alone would take an empty pipe
    assign fill_d = (in_capture && !filled) ? 2'(fill_q + 2'h1) : fill_q;
    // wait for the synchroniser to settle so a half-updated pipe is never taken
    assign take = in_capture && filled && bus_stable;

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            fill_q <= 2'h0;
        end else begin
            fill_q <= fill_d;
        end
    end

    always_comb begin
        case (state_q)
            pusc_pkg::PUSC_ST_RESET:   state_d = pusc_pkg::PUSC_ST_CAPTURE;
            pusc_pkg::PUSC_ST_CAPTURE: state_d = take ? pusc_pkg::PUSC_ST_HOLD
                                                      : pusc_pkg::PUSC_ST_CAPTURE;
            pusc_pkg::PUSC_ST_HOLD:    state_d = pusc_pkg::PUSC_ST_HOLD;
            default:                   state_d = pusc_pkg::PUSC_ST_RESET;
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            state_q <= pusc_pkg::PUSC_ST_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // one sample only; hold state never reloads, so later bus traffic is ignored
    always_ff @(posedge clock_in) begin
        if (!reset_n_in) begin
            image_q <= `PUSC_IMAGE_RESET;
        end else if (take) begin
            image_q <= bus_level;
        end
    end

    // read-only: there is no write path at all
    assign power_up_strap_image_out = image_q;
    assign image_valid_out = (state_q == pusc_pkg::PUSC_ST_HOLD);

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    function automatic logic [15:0] base_of(input logic [2:0] code);
        case (code)
            3'h0:    base_of = `PUSC_BASE_0;
            3'h2:    base_of = `PUSC_BASE_1;
            3'h4:    base_of = `PUSC_BASE_2;
            3'h6:    base_of = `PUSC_BASE_3;
            default: base_of = `PUSC_BASE_0;
        endcase
    endfunction : base_of

    wire [1:0] bus_field   = image_q[`PUSC_BUS_HI:`PUSC_BUS_LO];
    wire [2:0] base_field  = image_q[`PUSC_BASE_HI:`PUSC_BASE_LO];
    wire [3:0] dac_field   = image_q[`PUSC_DAC_HI:`PUSC_DAC_LO];
    wire [2:0] clk_field   = image_q[`PUSC_CLK_HI:`PUSC_CLK_LO];
    wire       rsv_bad     = image_q[`PUSC_RSV24_BIT]
                           | (|image_q[`PUSC_RSV11_HI:`PUSC_RSV11_LO]);

    assign host_bus_out          = pusc_pkg::pusc_bus_type'(bus_field);
    assign host_bus_reserved_out = (bus_field == pusc_pkg::PUSC_BUS_TEST)
                                 | (bus_field == pusc_pkg::PUSC_BUS_RSV);

    // odd codes are unassigned; fall back to the first group and flag it
    assign config_port_base_select_out = base_of(base_field);
    assign config_port_base_valid_out  = ~base_field[0];

    assign initial_operating_mode_out = image_q[`PUSC_MODE_BIT];
    assign initial_legacy_absent_out  = image_q[`PUSC_LEGACY_BIT];
    // sub-class 80h when legacy display absent, otherwise display controller 00h
    assign pci_sub_class_out = image_q[`PUSC_LEGACY_BIT] ? 8'h80 : 8'h00;

    assign palette_dac_type_out  = pusc_pkg::pusc_dac_type'(dac_field);
    assign palette_dac_known_out = (dac_field == pusc_pkg::PUSC_DAC_STD)
                                 | (dac_field == pusc_pkg::PUSC_DAC_WIDE);

    assign ext_regs_present_out = image_q[`PUSC_EXTREG_BIT];
    assign ext_regs_select_out  = image_q[`PUSC_EXTREG_BIT]
                                & clock_select_out_in[`PUSC_CLOCK_SELECT_OUT_EXTREG_BIT];

    assign clock_generator_kind_out = pusc_pkg::pusc_clk_type'(clk_field);
    // fixed clock mode relies on the board supplying 50 mhz as dac reference
    assign fixed_memory_clock_out = (clk_field == pusc_pkg::PUSC_CLK_FIXED);

    assign memory_depth_128k_out       = image_q[`PUSC_DEPTH_BIT];
    assign serial_buffer_size_half_out = image_q[`PUSC_SAM_BIT];
    assign serial_prom_type_out        = image_q[`PUSC_PROM_HI:`PUSC_PROM_LO];
    assign add_in_board_out            = image_q[`PUSC_BOARD_BIT];

    // reports a board that broke the must-be-zero straps; bits 23:16 left free
    assign strap_fault_out = rsv_bad;

    wire unused_read = image_read_in;
endmodule : pusc_core

// >>> verif/pusc_chk.sv
// checker for the strap capture block ports
`timescale 1ns/10ps
module pusc_chk #(
    parameter int WIDTH = 32
) (
    // clock and reset
    input wire logic                   clock_in,
    input wire logic                   reset_n_in,
    // pins and image
    input wire logic [WIDTH-1:0]       data_pull_oe_out,
    input wire logic [WIDTH-1:0]       data_pull_level_out,
    input wire logic [WIDTH-1:0]       power_up_strap_image_out,
    input wire logic                   image_valid_out,
    // decodes
    input wire pusc_pkg::pusc_bus_type host_bus_out,
    input wire logic [15:0]            config_port_base_select_out,
    input wire logic                   config_port_base_valid_out,
    input wire logic [7:0]             pci_sub_class_out,
    input wire logic [2:0]             clock_select_out_in,
    input wire logic                   ext_regs_select_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    a_pull_low: assert property (data_pull_oe_out == '1 && data_pull_level_out == '0)
        else $error("pull-down not on");
    a_reset_clear: assert property (disable iff (1'b0) !reset_n_in |=>
        power_up_strap_image_out == '0 && !image_valid_out) else $error("reset left image");
    a_valid_soon: assert property ($rose(reset_n_in) |-> ##[1:6] image_valid_out)
        else $error("no capture after release");
    a_image_hold: assert property (image_valid_out && $past(image_valid_out) |->
        $stable(power_up_strap_image_out)) else $error("image moved");
    a_bus_decode: assert property (host_bus_out == power_up_strap_image_out[31:30])
        else $error("host bus decode");
    a_base_decode: assert property (!power_up_strap_image_out[27] |->
        config_port_base_valid_out && config_port_base_select_out ==
        16'h9100 + {10'h0, power_up_strap_image_out[29:28], 4'h0}) else $error("base decode");
    a_legacy_code: assert property (pci_sub_class_out ==
        (power_up_strap_image_out[25] ? 8'h80 : 8'h00)) else $error("sub-class code");
    a_ext_select: assert property (ext_regs_select_out ==
        (power_up_strap_image_out[8] && clock_select_out_in[2])) else $error("ext select");
endmodule : pusc_chk

// >>> verif/pusc_board.sv
// board straps: pull-ups where fitted, device pull or a wandering float elsewhere
`timescale 1ns/10ps
module pusc_board (
    // clock
    input  wire logic        clock_in,
    // straps and later bus traffic
    input  wire logic [31:0] strap_fit_in,
    input  wire logic [31:0] drive_en_in,
    input  wire logic [31:0] drive_val_in,
    // device pulls
    input  wire logic [31:0] pull_oe_in,
    input  wire logic [31:0] pull_level_in,
    output logic      [31:0] bus_out
);
    logic [31:0] float_q = 32'h0;
    logic [31:0] up_w;
    // bit 24 and bits 11:9 never get a resistor
    assign up_w = strap_fit_in & ~32'h0100_0e00;
    // unpulled bits wander so a missing pull never reads as a lucky zero
    always_ff @(posedge clock_in) float_q <= ~float_q;
    assign bus_out = (drive_en_in & drive_val_in) | (~drive_en_in & (up_w |
        (pull_oe_in & pull_level_in) | (~pull_oe_in & float_q)));
endmodule : pusc_board

// >>> verif/power_up_strap_capture_bench.sv
// self-checking bench for the strap capture block
`timescale 1ns/10ps
module power_up_strap_capture_bench;
    typedef struct {logic [31:0] strap; logic [25:0] dec;} pusc_row_type;
    logic        clock_in = 1'b0;
    logic        reset_n_in = 1'b0;
    logic [31:0] strap_fit, drive_en, drive_val, data_bus_in, data_pull_oe_out;
    logic [31:0] data_pull_level_out, power_up_strap_image_out;
    logic        image_read_in, image_valid_out, host_bus_reserved_out;
    logic        config_port_base_valid_out, ext_regs_select_out, dac_known, fixed_clk;
    logic [2:0]  clock_select_out_in;
    logic [15:0] config_port_base_select_out, fld;
    logic [7:0]  pci_sub_class_out;
    logic [1:0]  hb;
    logic [31:0] s;
    int          n_fail = 0;
    int          cmp_count = 0;
    // strap, then {bus reserved, base valid, base, sub-class}
    pusc_row_type rows [6] = '{'{32'h0000_0000, {2'h3, 16'h9100, 8'h00}},
        '{32'h4000_3040, {2'h1, 16'h9100, 8'h00}},
        '{32'h5400_8031, {2'h1, 16'h9110, 8'h00}}, '{32'hf600_0000, {2'h3, 16'h9130, 8'h80}},
        '{32'h0800_0000, {2'h2, 16'h9100, 8'h00}}, '{32'ha200_0108, {2'h1, 16'h9120, 8'h80}}};
    always #4 clock_in = ~clock_in;
    pusc_board board (.clock_in, .strap_fit_in(strap_fit), .drive_en_in(drive_en),
        .drive_val_in(drive_val), .pull_oe_in(data_pull_oe_out),
        .pull_level_in(data_pull_level_out), .bus_out(data_bus_in));
    pusc_core uut (.clock_in, .reset_n_in, .data_bus_in, .data_pull_oe_out,
        .data_pull_level_out, .image_read_in, .power_up_strap_image_out, .image_valid_out,
        .host_bus_out(hb), .host_bus_reserved_out, .config_port_base_select_out,
        .config_port_base_valid_out, .initial_operating_mode_out(fld[15]),
        .initial_legacy_absent_out(fld[14]), .pci_sub_class_out,
        .palette_dac_type_out(fld[13:10]), .palette_dac_known_out(dac_known),
        .ext_regs_present_out(fld[9]), .clock_select_out_in, .ext_regs_select_out,
        .clock_generator_kind_out(fld[8:6]), .fixed_memory_clock_out(fixed_clk),
        .memory_depth_128k_out(fld[5]), .serial_buffer_size_half_out(fld[4]),
        .serial_prom_type_out(fld[3:2]), .add_in_board_out(fld[1]), .strap_fault_out(fld[0]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask : tick
    task automatic boot(input logic [31:0] st);
        int i;
        reset_n_in = 1'b0;
        strap_fit = st;
        drive_en = 32'h0;
        tick(2);
        reset_n_in = 1'b1;
        for (i = 0; i < 12 && image_valid_out !== 1'b1; i++) tick(1);
        chk({31'h0, image_valid_out}, 32'h1);
    endtask : boot
    task automatic end_of_test;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    initial begin
        strap_fit = 32'h0;
        drive_en = 32'h0;
        drive_val = 32'h0;
        image_read_in = 1'b0;
        clock_select_out_in = 3'h0;
        tick(8);
        foreach (rows[k]) begin
            s = rows[k].strap;
            boot(s);
            chk(power_up_strap_image_out, s);
            chk({4'h0, hb, host_bus_reserved_out, config_port_base_valid_out,
                config_port_base_select_out, pci_sub_class_out},
                {4'h0, s[31:30], rows[k].dec});
            chk({16'h0, fld}, {16'h0, s[26], s[25], s[15:12], s[8], s[7:5], s[4], s[3],
                s[2:1], s[0], 1'b0});
            chk({30'h0, dac_known, fixed_clk}, {30'h0,
                (s[15:12] == 4'h0) || (s[15:12] == 4'h8), s[7:5] == 3'h1});
        end
        // bus traffic and reads after capture must not reach the image
        drive_en = 32'hffff_ffff;
        drive_val = 32'h5a5a_a5a5;
        image_read_in = 1'b1;
        clock_select_out_in = 3'h4;
        tick(6);
        chk(power_up_strap_image_out, s);
        chk({31'h0, ext_regs_select_out}, 32'h1);
        clock_select_out_in = 3'h3;
        tick(1);
        chk({31'h0, ext_regs_select_out}, 32'h0);
        chk(data_pull_oe_out & ~data_pull_level_out, 32'hffff_ffff);
        reset_n_in = 1'b0;
        tick(2);
        chk({power_up_strap_image_out[30:0], image_valid_out}, 32'h0);
        // a board that breaks the must-be-zero strap is flagged
        drive_val = 32'h0100_0000;
        strap_fit = 32'h0;
        tick(1);
        reset_n_in = 1'b1;
        tick(8);
        chk(power_up_strap_image_out, 32'h0100_0000);
        chk({31'h0, fld[0]}, 32'h1);
        end_of_test;
    end
    initial begin
        #20000;
        n_fail++;
        end_of_test;
    end
endmodule : power_up_strap_capture_bench
bind pusc_core pusc_chk #(.WIDTH(WIDTH)) chk (.clock_in, .reset_n_in, .data_pull_oe_out,
    .data_pull_level_out, .power_up_strap_image_out, .image_valid_out, .host_bus_out,
    .config_port_base_select_out, .config_port_base_valid_out, .pci_sub_class_out,
    .clock_select_out_in, .ext_regs_select_out);
